// ### rtl/srr_map.svh
// bit positions, masks, widths and reset values of the status reporting registers
`ifndef SRR_MAP_SVH
`define SRR_MAP_SVH

// ---------------------------------------------------------------
// status summary byte bit positions
// ---------------------------------------------------------------
`define SRR_SB_OPER 7
`define SRR_SB_MASTER 6
`define SRR_SB_STD 5
`define SRR_SB_MSG 4
`define SRR_SB_QUES 3
`define SRR_SB_ERR 2
// summary bits able to feed the master summary flag
`define SRR_SB_MASK 8'hbc

// ---------------------------------------------------------------
// standard event latch bit positions
// ---------------------------------------------------------------
`define SRR_SE_POWER_UP 7
`define SRR_SE_PARSE 5
`define SRR_SE_EXEC 4
`define SRR_SE_DEVICE 3
`define SRR_SE_QUERY_LOSS 2
`define SRR_SE_OPS_DONE 0
// defined standard event bits; positions 6 and 1 stay zero
`define SRR_SE_MASK 8'hbd

// ---------------------------------------------------------------
// widths and reset values
// ---------------------------------------------------------------
`define SRR_OPER_WIDTH 7
`define SRR_QUES_WIDTH 11
`define SRR_RESP_WIDTH 16
`define SRR_SRE_RESET 8'h00
`define SRR_ESE_RESET 8'h00
`define SRR_EVT_RESET 8'h00

`endif

// ### rtl/srr_pkg.sv
// types shared by the status reporting block
package srr_pkg;

   // ---------------------------------------------------------------
   // host commands
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_READ_STATUS,
      CMD_READ_SRQ_MASK,
      CMD_WRITE_SRQ_MASK,
      CMD_READ_STD_EVENT,
      CMD_READ_STD_ENABLE,
      CMD_WRITE_STD_ENABLE,
      CMD_CLEAR_STATUS,
      CMD_OPS_DONE_ARM,
      CMD_READ_OPER_EVENT,
      CMD_READ_OPER_COND,
      CMD_READ_OPER_ENABLE,
      CMD_WRITE_OPER_ENABLE,
      CMD_READ_QUES_EVENT,
      CMD_READ_QUES_COND,
      CMD_READ_QUES_ENABLE,
      CMD_WRITE_QUES_ENABLE
   } srr_cmd_e;

   // ---------------------------------------------------------------
   // operations-done tracker states
   // ---------------------------------------------------------------
   typedef enum logic {
      OPC_IDLE,
      OPC_ARMED
   } srr_opc_e;

endpackage : srr_pkg

// ### rtl/srr_reg_set.sv
// one register set: optional condition, latching event and enable with summary
`timescale 1ns/10ps

module srr_reg_set #(
   parameter int WIDTH = 8,
   parameter bit HAS_COND = 1'b1,
   parameter logic [WIDTH-1:0] DEF_MASK = '1,
   parameter logic [WIDTH-1:0] ENA_RESET = '0
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic en_i,
   // sources
   input wire logic [WIDTH-1:0] cond_i,
   input wire logic [WIDTH-1:0] evt_i,
   // host side
   input wire logic clear_i,
   input wire logic ena_we_i,
   input wire logic [WIDTH-1:0] ena_wdata_i,
   // state
   output logic [WIDTH-1:0] event_o,
   output logic [WIDTH-1:0] enable_o,
   output logic [WIDTH-1:0] cond_o,
   output logic summary_o
);

   logic [WIDTH-1:0] event_q;
   logic [WIDTH-1:0] event_d;
   logic [WIDTH-1:0] enable_q;
   logic [WIDTH-1:0] rise;

   // ---------------------------------------------------------------
   // condition stage
   // ---------------------------------------------------------------
   generate
      if (HAS_COND) begin : g_cond
         logic [WIDTH-1:0] cond_prev_q;
         // previous level, for rising-transition events
         always_ff @(posedge clk_i) begin
            if (!rstn_i) begin
               cond_prev_q <= '0;
            end else if (en_i) begin
               cond_prev_q <= cond_i;
            end
         end
         assign rise = cond_i & ~cond_prev_q;
         assign cond_o = cond_i;
      end else begin : g_nocond
         assign rise = '0;
         assign cond_o = '0;
      end
   endgenerate

   // ---------------------------------------------------------------
   // event latch
   // ---------------------------------------------------------------
   // set beats clear so an event in the read cycle survives
   always_comb begin
      event_d = clear_i ? '0 : event_q;
      event_d = event_d | ((evt_i | rise) & DEF_MASK);
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         event_q <= '0;
      end else if (en_i) begin
         event_q <= event_d;
      end
   end

   // enable mask, the only host-writable part
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         enable_q <= ENA_RESET & DEF_MASK;
      end else if (en_i && ena_we_i) begin
         enable_q <= ena_wdata_i & DEF_MASK;
      end
   end

   assign event_o = event_q;
   assign enable_o = enable_q;
   assign summary_o = |(event_q & enable_q);

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   chk_enable_write: assert property (en_i && ena_we_i |=> enable_o == $past(ena_wdata_i & DEF_MASK))
      else $error("enable register did not take written mask");

endmodule : srr_reg_set

// ### rtl/srr_status_core.sv
// status reporting core: status byte, service request mask and three register sets
`timescale 1ns/10ps
`include "srr_map.svh"

// ---------------------------------------------------------------
// How it works
// - event bits latch and hold until cleared
// - condition registers mirror live state, read only
// - set summary is OR of event AND enable
// - host writes only enable masks
// - status byte summaries follow sources, unlatched
// - master flag bit 6, not cleared by read
// - master flag clears only via source or mask
// - bit 7 operation, bit 3 questionable summary
// - bit 5 standard event summary
// - bit 4 follows output message waiting
// - bit 2 follows error queue nonempty
// - standard event read returns and clears; mask RW
// - power-up sets standard event bit 7
// - parse errors set standard event bit 5
// - execution faults set standard event bit 4
// - device faults set standard event bit 3
// - lost query data sets standard event bit 2
// - armed operations-done sets bit 0 when idle
// - standard set has no condition register
// - replies and masks are binary-weighted values
// ---------------------------------------------------------------

module srr_status_core #(
   parameter int OPER_W = `SRR_OPER_WIDTH,
   parameter int QUES_W = `SRR_QUES_WIDTH
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic en_i,
   // host command port
   input wire logic cmd_valid_i,
   input srr_pkg::srr_cmd_e cmd_code_i,
   input wire logic [`SRR_RESP_WIDTH-1:0] cmd_data_i,
   // query response
   output logic resp_valid_o,
   output logic [`SRR_RESP_WIDTH-1:0] resp_value_o,
   // standard event sources
   input wire logic command_parse_error_i,
   input wire logic execution_fault_i,
   input wire logic device_specific_fault_i,
   input wire logic query_loss_fault_i,
   input wire logic ops_pending_i,
   // queue levels
   input wire logic output_message_waiting_i,
   input wire logic error_queue_nonempty_i,
   // live instrument conditions
   input wire logic [OPER_W-1:0] oper_cond_i,
   input wire logic [QUES_W-1:0] ques_cond_i,
   // status
   output logic [7:0] status_byte_o,
   output logic master_summary_flag_o
);

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   function automatic logic is_cmd(input logic valid, input srr_pkg::srr_cmd_e code,
                                   input srr_pkg::srr_cmd_e want);
      return valid && (code == want);
   endfunction : is_cmd

   logic rd_status;
   logic rd_sre;
   logic wr_sre;
   logic rd_std_ev;
   logic rd_std_en;
   logic wr_std_en;
   logic clear_all;
   logic ops_arm;
   logic rd_oper_ev;
   logic rd_oper_cond;
   logic rd_oper_en;
   logic wr_oper_en;
   logic rd_ques_ev;
   logic rd_ques_cond;
   logic rd_ques_en;
   logic wr_ques_en;

   // one strobe per command; an unknown strobe combination cannot occur
   assign rd_status = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_READ_STATUS);
   assign rd_sre = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_READ_SRQ_MASK);
   assign wr_sre = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_WRITE_SRQ_MASK);
   assign rd_std_ev = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_READ_STD_EVENT);
   assign rd_std_en = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_READ_STD_ENABLE);
   assign wr_std_en = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_WRITE_STD_ENABLE);
   assign clear_all = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_CLEAR_STATUS);
   assign ops_arm = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_OPS_DONE_ARM);
   assign rd_oper_ev = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_READ_OPER_EVENT);
   assign rd_oper_cond = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_READ_OPER_COND);
   assign rd_oper_en = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_READ_OPER_ENABLE);
   assign wr_oper_en = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_WRITE_OPER_ENABLE);
   assign rd_ques_ev = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_READ_QUES_EVENT);
   assign rd_ques_cond = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_READ_QUES_COND);
   assign rd_ques_en = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_READ_QUES_ENABLE);
   assign wr_ques_en = is_cmd(cmd_valid_i, cmd_code_i, srr_pkg::CMD_WRITE_QUES_ENABLE);

   // ---------------------------------------------------------------
   // power-up and operations-done tracking
   // ---------------------------------------------------------------
   logic pon_pending_q;
   srr_pkg::srr_opc_e opc_state_q;
   logic opc_done;

   // every reset release counts as an off-on transition
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         pon_pending_q <= 1'b1;
      end else if (en_i) begin
         pon_pending_q <= 1'b0;
      end
   end

   // finishing needs a cycle with no pending work after arming
   assign opc_done = (opc_state_q == srr_pkg::OPC_ARMED) && !ops_pending_i && !clear_all;

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         opc_state_q <= srr_pkg::OPC_IDLE;
      end else if (en_i) begin
         case (opc_state_q)
            srr_pkg::OPC_IDLE: begin
               if (ops_arm) begin
                  opc_state_q <= srr_pkg::OPC_ARMED;
               end
            end
            srr_pkg::OPC_ARMED: begin
               // clearing status also abandons a pending arm
               if (clear_all || !ops_pending_i) begin
                  opc_state_q <= srr_pkg::OPC_IDLE;
               end
            end
            default: begin
               opc_state_q <= srr_pkg::OPC_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // standard event register set
   // ---------------------------------------------------------------
   logic [7:0] std_set;
   logic [7:0] std_event;
   logic [7:0] std_enable;
   logic std_clear;
   logic std_sum;

   // each source pulse maps onto its fixed bit
   always_comb begin
      std_set = 8'h00;
      std_set[`SRR_SE_POWER_UP] = pon_pending_q;
      std_set[`SRR_SE_PARSE] = command_parse_error_i;
      std_set[`SRR_SE_EXEC] = execution_fault_i;
      std_set[`SRR_SE_DEVICE] = device_specific_fault_i;
      std_set[`SRR_SE_QUERY_LOSS] = query_loss_fault_i;
      std_set[`SRR_SE_OPS_DONE] = opc_done;
   end

   assign std_clear = rd_std_ev || clear_all;

   srr_reg_set #(
      .WIDTH(8),
      .HAS_COND(1'b0),
      .DEF_MASK(`SRR_SE_MASK),
      .ENA_RESET(`SRR_ESE_RESET)
   ) u_std_set (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .en_i(en_i),
      .cond_i(8'h00),
      .evt_i(std_set),
      .clear_i(std_clear),
      .ena_we_i(wr_std_en),
      .ena_wdata_i(cmd_data_i[7:0]),
      .event_o(std_event),
      .enable_o(std_enable),
      .cond_o(),
      .summary_o(std_sum)
   );

   // ---------------------------------------------------------------
   // operation and questionable register sets
   // ---------------------------------------------------------------
   logic [OPER_W-1:0] oper_event;
   logic [OPER_W-1:0] oper_enable;
   logic [OPER_W-1:0] oper_cond;
   logic oper_sum;
   logic [QUES_W-1:0] ques_event;
   logic [QUES_W-1:0] ques_enable;
   logic [QUES_W-1:0] ques_cond;
   logic ques_sum;

   // events come only from rising condition levels here
   srr_reg_set #(
      .WIDTH(OPER_W),
      .HAS_COND(1'b1)
   ) u_oper_set (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .en_i(en_i),
      .cond_i(oper_cond_i),
      .evt_i('0),
      .clear_i(rd_oper_ev || clear_all),
      .ena_we_i(wr_oper_en),
      .ena_wdata_i(cmd_data_i[OPER_W-1:0]),
      .event_o(oper_event),
      .enable_o(oper_enable),
      .cond_o(oper_cond),
      .summary_o(oper_sum)
   );

   srr_reg_set #(
      .WIDTH(QUES_W),
      .HAS_COND(1'b1)
   ) u_ques_set (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .en_i(en_i),
      .cond_i(ques_cond_i),
      .evt_i('0),
      .clear_i(rd_ques_ev || clear_all),
      .ena_we_i(wr_ques_en),
      .ena_wdata_i(cmd_data_i[QUES_W-1:0]),
      .event_o(ques_event),
      .enable_o(ques_enable),
      .cond_o(ques_cond),
      .summary_o(ques_sum)
   );

   // ---------------------------------------------------------------
   // status byte and service request mask
   // ---------------------------------------------------------------
   logic [7:0] sre_q;
   logic [7:0] sb_sum;
   logic [7:0] sb_d;
   logic [7:0] sb_q;
   logic mss_d;

   // bit 6 of the mask is never stored, so it cannot loop on itself
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         sre_q <= `SRR_SRE_RESET;
      end else if (en_i && wr_sre) begin
         sre_q <= cmd_data_i[7:0] & `SRR_SB_MASK;
      end
   end

   // summaries are plain wires: no latch between set and byte
   always_comb begin
      sb_sum = 8'h00;
      sb_sum[`SRR_SB_OPER] = oper_sum;
      sb_sum[`SRR_SB_STD] = std_sum;
      sb_sum[`SRR_SB_MSG] = output_message_waiting_i;
      sb_sum[`SRR_SB_QUES] = ques_sum;
      sb_sum[`SRR_SB_ERR] = error_queue_nonempty_i;
      mss_d = |(sb_sum & sre_q & `SRR_SB_MASK);
      sb_d = sb_sum;
      sb_d[`SRR_SB_MASTER] = mss_d;
   end

   // output copy, one cycle behind the summaries and queue levels; reads never touch it
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         sb_q <= 8'h00;
      end else if (en_i) begin
         sb_q <= sb_d;
      end
   end

   assign status_byte_o = sb_q;
   assign master_summary_flag_o = sb_q[`SRR_SB_MASTER];

   // ---------------------------------------------------------------
   // query responses
   // ---------------------------------------------------------------
   logic [`SRR_RESP_WIDTH-1:0] resp_d;
   logic resp_vd;
   logic [`SRR_RESP_WIDTH-1:0] resp_q;
   logic resp_valid_q;

   // value is the binary-weighted sum; text formatting lies upstream
   always_comb begin
      resp_d = '0;
      resp_vd = 1'b1;
      if (rd_status) begin
         resp_d = {8'h00, sb_d};
      end else if (rd_sre) begin
         resp_d = {8'h00, sre_q};
      end else if (rd_std_ev) begin
         resp_d = {8'h00, std_event};
      end else if (rd_std_en) begin
         resp_d = {8'h00, std_enable};
      end else if (rd_oper_ev) begin
         resp_d = `SRR_RESP_WIDTH'(oper_event);
      end else if (rd_oper_cond) begin
         resp_d = `SRR_RESP_WIDTH'(oper_cond);
      end else if (rd_oper_en) begin
         resp_d = `SRR_RESP_WIDTH'(oper_enable);
      end else if (rd_ques_ev) begin
         resp_d = `SRR_RESP_WIDTH'(ques_event);
      end else if (rd_ques_cond) begin
         resp_d = `SRR_RESP_WIDTH'(ques_cond);
      end else if (rd_ques_en) begin
         resp_d = `SRR_RESP_WIDTH'(ques_enable);
      end else begin
         resp_vd = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         resp_q <= '0;
         resp_valid_q <= 1'b0;
      end else if (en_i) begin
         resp_q <= resp_d;
         resp_valid_q <= resp_vd;
      end
   end

   assign resp_value_o = resp_q;
   assign resp_valid_o = resp_valid_q;

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   property p_sets(logic ev, int b);
      rstn_i && en_i && ev |=> std_event[b]; // sampled reset keeps the release edge out
   endproperty

   sequence s_arm;
      en_i && ops_arm;
   endsequence

   sequence s_idle_run;
      en_i && !ops_pending_i && !clear_all;
   endsequence

   chk_event_sticky: assert property (en_i && !std_clear |=> (std_event & $past(std_event)) == $past(std_event))
      else $error("standard event bit dropped without a clear");
   chk_cond_read: assert property (en_i && rd_oper_cond |=> resp_valid_o && resp_value_o == $past(16'(oper_cond_i)))
      else $error("condition read did not show live state");
   chk_std_summary: assert property ($past(en_i) |-> sb_q[5] == $past(|(std_event & std_enable)))
      else $error("standard summary does not follow event and enable");
   chk_clear_unlatch: assert property (en_i && std_clear && std_set == 8'h00 |=> std_event == 8'h00 ##1 !sb_q[5])
      else $error("cleared standard events left summary set");
   chk_master_flag: assert property ($past(en_i) |-> sb_q[6] == |(sb_q & $past(sre_q) & 8'hbc))
      else $error("master summary flag disagrees with mask");
   chk_read_keeps: assert property (en_i && rd_status |=> std_event == ($past(std_event) | $past(std_set)))
      else $error("status byte read altered event state");
   chk_oper_ques: assert property ($past(en_i) |-> sb_q[7] == $past(oper_sum) && sb_q[3] == $past(ques_sum))
      else $error("operation or questionable summary bit wrong");
   chk_queue_bits: assert property ($past(en_i) |-> sb_q[4] == $past(output_message_waiting_i)
                                    && sb_q[2] == $past(error_queue_nonempty_i))
      else $error("message or error queue bit wrong");
   chk_std_read: assert property (en_i && rd_std_ev |=> resp_valid_o && resp_value_o == {8'h00, $past(std_event)})
      else $error("standard event read returned wrong value");
   chk_power_up: assert property (p_sets(pon_pending_q, 7))
      else $error("power-up did not set bit 7");
   chk_parse_err: assert property (p_sets(command_parse_error_i, 5))
      else $error("parse error did not set bit 5");
   chk_exec_fault: assert property (p_sets(execution_fault_i, 4))
      else $error("execution fault did not set bit 4");
   chk_dev_fault: assert property (p_sets(device_specific_fault_i, 3))
      else $error("device fault did not set bit 3");
   chk_query_loss: assert property (p_sets(query_loss_fault_i, 2))
      else $error("query loss did not set bit 2");
   chk_ops_done: assert property (s_arm ##1 s_idle_run |=> std_event[0])
      else $error("operations done bit not set after arm");
   chk_undef_zero: assert property (sb_q[1:0] == 2'b00 && std_event[6] == 1'b0 && std_event[1] == 1'b0)
      else $error("undefined bit position reads nonzero");

endmodule : srr_status_core

// ### verif/srr_host_model.sv
// host-side model that issues status commands and collects replies
`timescale 1ns/10ps

module srr_host_model (
   // clock
   input wire logic clk_i,
   // command port
   output logic cmd_valid_o,
   output srr_pkg::srr_cmd_e cmd_code_o,
   output logic [15:0] cmd_data_o,
   // reply
   input wire logic resp_valid_i,
   input wire logic [15:0] resp_value_i
);
   // idle port at time zero
   initial begin
      cmd_valid_o = 1'b0;
      cmd_code_o = srr_pkg::CMD_READ_STATUS;
      cmd_data_o = 16'h0000;
   end

   // one strobe; data is a binary-weighted mask, scrambled once released
   task automatic send(input srr_pkg::srr_cmd_e code, input logic [7:0] data);
      @(posedge clk_i);
      cmd_valid_o <= 1'b1;
      cmd_code_o <= code;
      cmd_data_o <= {8'h00, data};
      @(posedge clk_i);
      cmd_valid_o <= 1'b0;
      cmd_data_o <= ~{8'h00, data};
   endtask : send

   // reply is a one-cycle pulse, so it is caught mid-cycle under a bound
   task automatic query(input srr_pkg::srr_cmd_e code, output logic [15:0] value);
      value = 16'hxxxx;
      send(code, 8'h00);
      for (int n = 0; n < 4; n++) begin
         @(negedge clk_i);
         if (resp_valid_i === 1'b1) begin
            value = resp_value_i;
            break;
         end
      end
   endtask : query
endmodule : srr_host_model

// ### verif/test_status_reporting_registers.sv
// self-checking bench for the status reporting core
`timescale 1ns/10ps

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, a, b); end end

module test_status_reporting_registers;
   logic clk_i = 1'b0, rstn_i = 1'b0;
   logic cmd_valid, resp_valid, master_summary_flag, opend = 1'b0, msgw = 1'b0, errq = 1'b0, en = 1'b1;
   srr_pkg::srr_cmd_e cmd_code;
   logic [15:0] cmd_data, resp_value, v;
   logic [3:0] flt = 4'h0;
   logic [6:0] oper = 7'h00;
   logic [10:0] ques = 11'h000;
   logic [7:0] sb;
   int fail_count = 0, comparisons = 0, cyc = 0;

   srr_status_core srr_status_core_i (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(en),
      .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_data_i(cmd_data),
      .resp_valid_o(resp_valid), .resp_value_o(resp_value),
      .command_parse_error_i(flt[3]), .execution_fault_i(flt[2]),
      .device_specific_fault_i(flt[1]), .query_loss_fault_i(flt[0]),
      .ops_pending_i(opend), .output_message_waiting_i(msgw), .error_queue_nonempty_i(errq),
      .oper_cond_i(oper), .ques_cond_i(ques), .status_byte_o(sb), .master_summary_flag_o(master_summary_flag));
   srr_host_model srr_host_model_i (.clk_i(clk_i), .cmd_valid_o(cmd_valid), .cmd_code_o(cmd_code),
      .cmd_data_o(cmd_data), .resp_valid_i(resp_valid), .resp_value_i(resp_value));

   // clock and hang guard
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fail_count++;
         conclude();
      end
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude

   // status byte is registered, so let it settle before looking
   task automatic chk_sb(input logic [7:0] e);
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      `CHK(sb, e)
      `CHK(master_summary_flag, e[6])
   endtask : chk_sb

   // read a register and compare its zero-extended value
   task automatic rd(input srr_pkg::srr_cmd_e c, input logic [10:0] e);
      srr_host_model_i.query(c, v);
      `CHK(v, {5'h00, e})
   endtask : rd

   initial begin
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(srr_pkg::CMD_READ_STD_EVENT, 11'h080);
      rd(srr_pkg::CMD_READ_STD_EVENT, 11'h000);
      // each fault, raised twice, reads back once at its own weight
      for (int i = 0; i < 4; i++) begin
         repeat (2) begin
            @(posedge clk_i) flt[i] <= 1'b1;
            @(posedge clk_i) flt[i] <= 1'b0;
         end
         rd(srr_pkg::CMD_READ_STD_EVENT, 11'h004 << i);
      end
      rd(srr_pkg::CMD_READ_STD_EVENT, 11'h000);
      $display("test events done");
      srr_host_model_i.send(srr_pkg::CMD_WRITE_STD_ENABLE, 8'hff);
      rd(srr_pkg::CMD_READ_STD_ENABLE, 11'h0bd);
      srr_host_model_i.send(srr_pkg::CMD_WRITE_SRQ_MASK, 8'hff);
      rd(srr_pkg::CMD_READ_SRQ_MASK, 11'h0bc);
      @(posedge clk_i) flt[2] <= 1'b1;
      @(posedge clk_i) flt[2] <= 1'b0;
      chk_sb(8'h60);
      rd(srr_pkg::CMD_READ_STATUS, 11'h060);
      rd(srr_pkg::CMD_READ_STATUS, 11'h060);
      srr_host_model_i.send(srr_pkg::CMD_WRITE_SRQ_MASK, 8'h00);
      chk_sb(8'h20);
      srr_host_model_i.send(srr_pkg::CMD_WRITE_SRQ_MASK, 8'hff);
      rd(srr_pkg::CMD_READ_STD_EVENT, 11'h010);
      chk_sb(8'h00);
      @(posedge clk_i) begin
         msgw <= 1'b1;
         errq <= 1'b1;
      end
      chk_sb(8'h54);
      @(posedge clk_i) begin
         msgw <= 1'b0;
         errq <= 1'b0;
      end
      chk_sb(8'h00);
      $display("test status byte done");
      srr_host_model_i.send(srr_pkg::CMD_WRITE_OPER_ENABLE, 8'hff);
      @(posedge clk_i) oper <= 7'h01;
      rd(srr_pkg::CMD_READ_OPER_COND, 11'h001);
      @(posedge clk_i) oper <= 7'h00;
      rd(srr_pkg::CMD_READ_OPER_COND, 11'h000);
      chk_sb(8'hc0);
      srr_host_model_i.send(srr_pkg::CMD_CLEAR_STATUS, 8'h00);
      chk_sb(8'h00);
      rd(srr_pkg::CMD_READ_OPER_EVENT, 11'h000);
      rd(srr_pkg::CMD_READ_OPER_ENABLE, 11'h07f);
      srr_host_model_i.send(srr_pkg::CMD_WRITE_QUES_ENABLE, 8'hff);
      @(posedge clk_i) ques <= 11'h001;
      chk_sb(8'h48);
      rd(srr_pkg::CMD_READ_QUES_COND, 11'h001);
      rd(srr_pkg::CMD_READ_QUES_ENABLE, 11'h0ff);
      rd(srr_pkg::CMD_READ_QUES_EVENT, 11'h001);
      @(posedge clk_i) ques <= 11'h000;
      chk_sb(8'h00);
      // a fault seen only while the clock enable is low must not latch
      @(posedge clk_i) begin
         en <= 1'b0;
         flt[0] <= 1'b1;
      end
      @(posedge clk_i) flt[0] <= 1'b0;
      @(posedge clk_i) en <= 1'b1;
      rd(srr_pkg::CMD_READ_STD_EVENT, 11'h000);
      $display("test register sets done");
      @(posedge clk_i) opend <= 1'b1;
      srr_host_model_i.send(srr_pkg::CMD_OPS_DONE_ARM, 8'h00);
      repeat (5) @(posedge clk_i);
      rd(srr_pkg::CMD_READ_STD_EVENT, 11'h000);
      @(posedge clk_i) opend <= 1'b0;
      repeat (3) @(posedge clk_i);
      rd(srr_pkg::CMD_READ_STD_EVENT, 11'h001);
      // arming with nothing pending completes on the very next cycle
      srr_host_model_i.send(srr_pkg::CMD_OPS_DONE_ARM, 8'h00);
      rd(srr_pkg::CMD_READ_STD_EVENT, 11'h001);
      $display("test operations done done");
      conclude();
   end
endmodule : test_status_reporting_registers
